// File: hw/swc_sleep_ctrl.sv
// Purpose: Decides when a sleeping processor core halts and when it wakes up.
// Assumes: Core and interrupt controller inputs are on i_clk; lower priority number is more urgent.
// Notes: Control bits sit in a register reached over AXI4-Lite.
`timescale 1ns/1ns
`include "swc_regs.svh"

module swc_sleep_ctrl (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // AXI4-Lite write channels.
    input wire logic i_s_axi_awvalid,
    input wire logic [`SWC_ADDR_W-1:0] i_s_axi_awaddr,
    output logic o_s_axi_awready,
    input wire logic i_s_axi_wvalid,
    input wire logic [`SWC_DATA_W-1:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    output logic o_s_axi_wready,
    output logic o_s_axi_bvalid,
    output logic [1:0] o_s_axi_bresp,
    input wire logic i_s_axi_bready,
    // AXI4-Lite read channels.
    input wire logic i_s_axi_arvalid,
    input wire logic [`SWC_ADDR_W-1:0] i_s_axi_araddr,
    output logic o_s_axi_arready,
    output logic o_s_axi_rvalid,
    output logic [`SWC_DATA_W-1:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    input wire logic i_s_axi_rready,
    // Core instruction strobes.
    input wire logic i_wait_for_interrupt_instr,
    input wire logic i_wait_for_event_instr,
    input wire logic i_send_event_instr,
    input wire logic i_exc_return_to_thread,
    // Nested interrupt controller.
    input wire logic i_exc_req,
    input wire logic i_exc_enabled,
    input wire logic [`SWC_PRIO_W-1:0] i_exc_prio,
    input wire logic [`SWC_PRIO_W-1:0] i_cur_prio,
    input wire logic i_new_pending,
    // Core control.
    output logic o_core_halt,
    output logic o_wake,
    output logic o_evt_wait_skip,
    output logic o_exc_entry_ok,
    output logic o_event_reg
);

    swc_pkg::swc_state_e state_q;
    swc_pkg::swc_state_e state_d;
    swc_pkg::swc_cause_e cause_q;
    logic [`SWC_CTRL_W-1:0] ctrl_q;
    logic event_q;
    logic halt_q;
    logic wake_q;
    logic skip_q;
    logic defer_q;

    logic wr_en;
    swc_pkg::swc_wr_s wr;
    logic [`SWC_ADDR_W-1:0] rd_addr;
    logic [`SWC_DATA_W-1:0] rd_data;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Register access.
    wire wr_ctrl_hit = (wr.addr == `SWC_OFF_CTRL);
    wire wr_stat_hit = (wr.addr == `SWC_OFF_STAT);
    wire rd_ctrl_hit = (rd_addr == `SWC_OFF_CTRL);
    wire rd_stat_hit = (rd_addr == `SWC_OFF_STAT);
    swc_axil_slave u_bus (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_awvalid(i_s_axi_awvalid),
        .i_awaddr(i_s_axi_awaddr),
        .o_awready(o_s_axi_awready),
        .i_wvalid(i_s_axi_wvalid),
        .i_wdata(i_s_axi_wdata),
        .i_wstrb(i_s_axi_wstrb),
        .o_wready(o_s_axi_wready),
        .o_bvalid(o_s_axi_bvalid),
        .o_bresp(o_s_axi_bresp),
        .i_bready(i_s_axi_bready),
        .i_arvalid(i_s_axi_arvalid),
        .i_araddr(i_s_axi_araddr),
        .o_arready(o_s_axi_arready),
        .o_rvalid(o_s_axi_rvalid),
        .o_rdata(o_s_axi_rdata),
        .o_rresp(o_s_axi_rresp),
        .i_rready(i_s_axi_rready),
        .o_wr_en(wr_en),
        .o_wr(wr),
        .i_wr_ok(wr_ctrl_hit | wr_stat_hit),
        .o_rd_addr(rd_addr),
        .i_rd_data(rd_data),
        .i_rd_ok(rd_ctrl_hit | rd_stat_hit)
    );

    wire ctrl_we = wr_en & wr_ctrl_hit & wr.strb[0];

    // Status word; reserved bits read as zero.
    wire [`SWC_DATA_W-1:0] stat_word = {26'h0, cause_q, defer_q, event_q,
        (state_q == swc_pkg::ST_SLEEP_EVT), halt_q};
    wire [`SWC_DATA_W-1:0] ctrl_word = {28'h0, ctrl_q};

    assign rd_data = rd_ctrl_hit ? ctrl_word : (rd_stat_hit ? stat_word : 32'h0000_0000);

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ctrl_q <= `SWC_CTRL_RST;
        end else if (ctrl_we) begin
            ctrl_q <= wr.data[`SWC_CTRL_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Wake-up conditions.
    wire sleep_on_exit = ctrl_q[`SWC_CTRL_SLEEP_EXIT];
    wire ev_on_pend = ctrl_q[`SWC_CTRL_EV_ON_PEND];
    wire irq_mask = ctrl_q[`SWC_CTRL_IRQ_MASK];
    wire fault_mask = ctrl_q[`SWC_CTRL_FAULT_MASK];

    // An enabled exception that outranks the current priority.
    wire prio_ok = i_exc_req & i_exc_enabled & (i_exc_prio < i_cur_prio);
    // The fault mask blocks both wake and entry; the interrupt mask alone only defers entry.
    wire exc_wake = prio_ok & ~fault_mask;
    wire entry_ok = prio_ok & ~irq_mask & ~fault_mask;
    wire pend_event = ev_on_pend & i_new_pending;
    wire event_set = i_send_event_instr | pend_event;
    wire evw_event_wake = event_q | pend_event;

    wire in_run = (state_q == swc_pkg::ST_RUN);
    // An interrupt wait in the same cycle takes priority and leaves the event untouched.
    wire evw_hit = in_run & i_wait_for_event_instr & ~i_wait_for_interrupt_instr & event_q;
    wire evw_sleep = in_run & i_wait_for_event_instr & ~event_q & ~exc_wake;
    wire intw_sleep = in_run & i_wait_for_interrupt_instr & ~exc_wake;
    wire exit_sleep = in_run & i_exc_return_to_thread & sleep_on_exit & ~exc_wake;
    wire leave_intw = (state_q == swc_pkg::ST_SLEEP_INTR) & exc_wake;
    wire leave_evw = (state_q == swc_pkg::ST_SLEEP_EVT) & (exc_wake | evw_event_wake);
    wire wake_now = leave_intw | leave_evw;
    // An event is consumed by an event wait that skips or by an event-wait wake.
    wire event_clr = evw_hit | (leave_evw & event_q);

    assign o_exc_entry_ok = entry_ok & in_run;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Sleep state machine.
    always_comb begin
        state_d = state_q;
        case (state_q)
            swc_pkg::ST_RUN: begin
                if (intw_sleep | exit_sleep) begin
                    state_d = swc_pkg::ST_SLEEP_INTR;
                end else if (evw_sleep) begin
                    state_d = swc_pkg::ST_SLEEP_EVT;
                end
            end
            swc_pkg::ST_SLEEP_INTR: begin
                if (leave_intw) begin
                    state_d = swc_pkg::ST_RUN;
                end
            end
            swc_pkg::ST_SLEEP_EVT: begin
                if (leave_evw) begin
                    state_d = swc_pkg::ST_RUN;
                end
            end
            default: begin
                state_d = swc_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_q <= swc_pkg::ST_RUN;
            halt_q <= 1'b0;
            wake_q <= 1'b0;
            skip_q <= 1'b0;
        end else begin
            state_q <= state_d;
            halt_q <= (state_d != swc_pkg::ST_RUN);
            wake_q <= wake_now;
            skip_q <= evw_hit;
        end
    end

    // A new event in the same cycle as a clear is kept.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            event_q <= 1'b0;
        end else begin
            event_q <= (event_q & ~event_clr) | event_set;
        end
    end

    // Wake cause and whether handler entry is held back by the interrupt mask.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cause_q <= swc_pkg::CAUSE_NONE;
            defer_q <= 1'b0;
        end else begin
            if (wake_now) begin
                cause_q <= exc_wake ? swc_pkg::CAUSE_EXC : swc_pkg::CAUSE_EVENT;
            end
            defer_q <= in_run & prio_ok & irq_mask & ~fault_mask;
        end
    end

    assign o_core_halt = halt_q;
    assign o_wake = wake_q;
    assign o_evt_wait_skip = skip_q;
    assign o_event_reg = event_q;

endmodule : swc_sleep_ctrl

// File: hw/swc_regs.svh
// Purpose: Register offsets, field positions and reset values of the sleep and wake-up control.
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus, one aligned word per register.
// Notes: Definitions only.
`ifndef SWC_REGS_SVH
`define SWC_REGS_SVH

`define SWC_ADDR_W 8
`define SWC_DATA_W 32
`define SWC_PRIO_W 3

`define SWC_OFF_CTRL 8'h00
`define SWC_OFF_STAT 8'h04

`define SWC_CTRL_SLEEP_EXIT 0
`define SWC_CTRL_EV_ON_PEND 1
`define SWC_CTRL_IRQ_MASK 2
`define SWC_CTRL_FAULT_MASK 3
`define SWC_CTRL_W 4
`define SWC_CTRL_RST 4'h0

`define SWC_STAT_ASLEEP 0
`define SWC_STAT_IN_EVT 1
`define SWC_STAT_EVENT 2
`define SWC_STAT_DEFER 3
`define SWC_STAT_CAUSE_LO 4
`define SWC_STAT_CAUSE_HI 5

`define SWC_RESP_OKAY 2'h0
`define SWC_RESP_SLVERR 2'h2

`endif

// File: hw/swc_pkg.sv
// Purpose: Types shared by the sleep and wake-up control files.
// Assumes: Nothing beyond the register header.
// Notes: Nothing is imported; users write swc_pkg::name.
`include "swc_regs.svh"

package swc_pkg;

    typedef enum {
        ST_RUN,
        ST_SLEEP_INTR,
        ST_SLEEP_EVT
    } swc_state_e;

    typedef enum logic [1:0] {
        CAUSE_NONE,
        CAUSE_EXC,
        CAUSE_EVENT
    } swc_cause_e;

    typedef struct packed {
        logic [`SWC_ADDR_W-1:0] addr;
        logic [`SWC_DATA_W-1:0] data;
        logic [3:0] strb;
    } swc_wr_s;

endpackage : swc_pkg

// File: hw/swc_axil_slave.sv
// Purpose: AXI4-Lite slave front end that turns bus transfers into register strobes.
// Assumes: One write and one read under way at a time; address and data may come in any order.
// Notes: The register file and the decode live in the instantiating module.
`timescale 1ns/1ns
`include "swc_regs.svh"

module swc_axil_slave (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Write channels.
    input wire logic i_awvalid,
    input wire logic [`SWC_ADDR_W-1:0] i_awaddr,
    output logic o_awready,
    input wire logic i_wvalid,
    input wire logic [`SWC_DATA_W-1:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_wready,
    output logic o_bvalid,
    output logic [1:0] o_bresp,
    input wire logic i_bready,
    // Read channels.
    input wire logic i_arvalid,
    input wire logic [`SWC_ADDR_W-1:0] i_araddr,
    output logic o_arready,
    output logic o_rvalid,
    output logic [`SWC_DATA_W-1:0] o_rdata,
    output logic [1:0] o_rresp,
    input wire logic i_rready,
    // Register side.
    output logic o_wr_en,
    output swc_pkg::swc_wr_s o_wr,
    input wire logic i_wr_ok,
    output logic [`SWC_ADDR_W-1:0] o_rd_addr,
    input wire logic [`SWC_DATA_W-1:0] i_rd_data,
    input wire logic i_rd_ok
);

    logic aw_full_q;
    logic w_full_q;
    logic [`SWC_ADDR_W-1:0] awaddr_q;
    logic [`SWC_DATA_W-1:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [`SWC_DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;

    wire aw_take = i_awvalid & o_awready;
    wire w_take = i_wvalid & o_wready;
    wire ar_take = i_arvalid & o_arready;

    assign o_awready = ~aw_full_q & ~bvalid_q;
    assign o_wready = ~w_full_q & ~bvalid_q;
    assign o_arready = ~rvalid_q;
    assign o_wr_en = aw_full_q & w_full_q & ~bvalid_q;
    assign o_wr = '{addr: awaddr_q, data: wdata_q, strb: wstrb_q};
    assign o_rd_addr = i_araddr;
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign o_rvalid = rvalid_q;
    assign o_rdata = rdata_q;
    assign o_rresp = rresp_q;

    ////////////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `SWC_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_full_q <= 1'b1;
                awaddr_q <= i_awaddr;
            end
            if (w_take) begin
                w_full_q <= 1'b1;
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
            end
            if (o_wr_en) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= i_wr_ok ? `SWC_RESP_OKAY : `SWC_RESP_SLVERR;
            end else if (bvalid_q & i_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `SWC_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= i_rd_data;
            rresp_q <= i_rd_ok ? `SWC_RESP_OKAY : `SWC_RESP_SLVERR;
        end else if (rvalid_q & i_rready) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule : swc_axil_slave

// File: tb/swc_sleep_chk.sv
// Purpose: Port assertions for the sleep and wake-up control.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to every swc_sleep_ctrl instance.
`timescale 1ns/1ns
`include "swc_regs.svh"

module swc_sleep_chk (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Core and controller inputs.
    input wire logic i_wait_for_interrupt_instr,
    input wire logic i_wait_for_event_instr,
    input wire logic i_send_event_instr,
    input wire logic i_exc_return_to_thread,
    input wire logic i_exc_req,
    input wire logic i_exc_enabled,
    input wire logic [`SWC_PRIO_W-1:0] i_exc_prio,
    input wire logic [`SWC_PRIO_W-1:0] i_cur_prio,
    input wire logic i_new_pending,
    // Core control outputs.
    input wire logic o_core_halt,
    input wire logic o_wake,
    input wire logic o_evt_wait_skip,
    input wire logic o_exc_entry_ok,
    input wire logic o_event_reg
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    wire prio_ok = i_exc_req && i_exc_enabled && (i_exc_prio < i_cur_prio);
    wire evw_go = !o_core_halt && !i_wait_for_interrupt_instr && i_wait_for_event_instr;
    wire no_cause = !prio_ok && !i_new_pending && !o_event_reg && !i_send_event_instr;

    property p_halt_wake; $fell(o_core_halt) && !$past(i_sys_rst) |-> o_wake; endproperty
    a_halt_wake: assert property (p_halt_wake) else $error("halt dropped without wake");
    property p_wake_one; o_wake |=> !o_wake; endproperty
    a_wake_one: assert property (p_wake_one) else $error("wake pulse too long");
    property p_intw_sleep; !o_core_halt && i_wait_for_interrupt_instr && !prio_ok
        |=> o_core_halt; endproperty
    a_intw_sleep: assert property (p_intw_sleep) else $error("interrupt wait did not halt");
    property p_evw_sleep; evw_go && no_cause |=> o_core_halt; endproperty
    a_evw_sleep: assert property (p_evw_sleep) else $error("wait for event did not halt");
    property p_evw_skip; evw_go && o_event_reg && !i_send_event_instr && !i_new_pending
        && !i_exc_return_to_thread |=> o_evt_wait_skip && !o_core_halt && !o_event_reg;
    endproperty
    a_evw_skip: assert property (p_evw_skip) else $error("event set but core halted");
    property p_stay; o_core_halt && no_cause |=> o_core_halt; endproperty
    a_stay: assert property (p_stay) else $error("woke without a cause");
    property p_send_evt; !o_core_halt && i_send_event_instr |=> o_event_reg; endproperty
    a_send_evt: assert property (p_send_evt) else $error("send event lost");
    property p_entry; o_exc_entry_ok |-> prio_ok && !o_core_halt; endproperty
    a_entry: assert property (p_entry) else $error("entry allowed without priority");
    property p_skip_cause;
        $rose(o_evt_wait_skip) |-> $past(i_wait_for_event_instr) && $past(o_event_reg);
    endproperty
    a_skip_cause: assert property (p_skip_cause) else $error("skip without event");
endmodule : swc_sleep_chk

bind swc_sleep_ctrl swc_sleep_chk swc_sleep_chk_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_wait_for_interrupt_instr(i_wait_for_interrupt_instr),
    .i_wait_for_event_instr(i_wait_for_event_instr), .i_send_event_instr(i_send_event_instr),
    .i_exc_return_to_thread(i_exc_return_to_thread),
    .i_exc_req(i_exc_req), .i_exc_enabled(i_exc_enabled), .i_exc_prio(i_exc_prio),
    .i_cur_prio(i_cur_prio), .i_new_pending(i_new_pending), .o_core_halt(o_core_halt),
    .o_wake(o_wake), .o_evt_wait_skip(o_evt_wait_skip), .o_exc_entry_ok(o_exc_entry_ok),
    .o_event_reg(o_event_reg));

// File: tb/swc_nic_model.sv
// Purpose: Interrupt controller model that holds one pending exception.
// Assumes: Bench raises and drops the request with one-cycle pulses.
// Notes: Priority wanders while nothing is pending.
`timescale 1ns/1ns
`include "swc_regs.svh"

module swc_nic_model (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Bench commands.
    input wire logic i_raise,
    input wire logic i_drop,
    input wire logic i_en,
    input wire logic [`SWC_PRIO_W-1:0] i_prio,
    input wire logic [`SWC_PRIO_W-1:0] i_cur,
    // Exception signalling towards the core.
    output logic o_req,
    output logic o_en,
    output logic [`SWC_PRIO_W-1:0] o_prio,
    output logic [`SWC_PRIO_W-1:0] o_cur,
    output logic o_new_pend
);
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            {o_req, o_en, o_new_pend, o_prio, o_cur} <= 9'h000;
        end else begin
            o_new_pend <= i_raise && !o_req;
            o_req <= i_raise || (o_req && !i_drop);
            o_en <= i_en;
            o_cur <= i_cur;
            o_prio <= i_raise ? i_prio : (o_req ? o_prio : ~o_prio);
        end
    end
endmodule : swc_nic_model

// File: tb/swc_sleep_ctrl_tb_top.sv
// Purpose: Self-checking bench for the sleep and wake-up control.
// Assumes: 125 MHz clock, synchronous reset held 16 cycles.
// Notes: Registers go over AXI4-Lite; the controller is swc_nic_model.
`timescale 1ns/1ns
`include "swc_regs.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end

module swc_sleep_ctrl_tb_top;
    logic clk = 1'b0, rst = 1'b1;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, req, men, np, halt, wake, skip, eok, ev;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [3:0] wstrb = 0, ins = 0;
    logic [1:0] bresp, rresp, r;
    logic raise = 0, drop = 0, en = 0;
    logic [2:0] prio = 0, cur = 0, mprio, mcur, p, c;
    int n_fail = 0, checks_done = 0, cyc = 0, seed = 75165;

    always #4 clk = ~clk;

    swc_nic_model swc_nic_model_inst (.i_clk(clk), .i_sys_rst(rst), .i_raise(raise),
        .i_drop(drop), .i_en(en), .i_prio(prio), .i_cur(cur), .o_req(req), .o_en(men),
        .o_prio(mprio), .o_cur(mcur), .o_new_pend(np));
    swc_sleep_ctrl swc_sleep_ctrl_inst (.i_clk(clk), .i_sys_rst(rst),
        .i_s_axi_awvalid(awvalid), .i_s_axi_awaddr(awaddr), .o_s_axi_awready(awready),
        .i_s_axi_wvalid(wvalid), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
        .o_s_axi_wready(wready), .o_s_axi_bvalid(bvalid), .o_s_axi_bresp(bresp),
        .i_s_axi_bready(bready), .i_s_axi_arvalid(arvalid), .i_s_axi_araddr(araddr),
        .o_s_axi_arready(arready), .o_s_axi_rvalid(rvalid), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp), .i_s_axi_rready(rready),
        .i_wait_for_interrupt_instr(ins[0]), .i_wait_for_event_instr(ins[1]),
        .i_send_event_instr(ins[2]), .i_exc_return_to_thread(ins[3]), .i_exc_req(req),
        .i_exc_enabled(men), .i_exc_prio(mprio), .i_cur_prio(mcur), .i_new_pending(np),
        .o_core_halt(halt), .o_wake(wake), .o_evt_wait_skip(skip), .o_exc_entry_ok(eok),
        .o_event_reg(ev));

    task conclude;
        if (n_fail == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    // An interrupt wait stays asleep unless the exception is enabled and outranks the level.
    function automatic logic exp_asleep(input logic e, input logic [2:0] pr,
        input logic [2:0] cu);
        return !(e && pr < cu);
    endfunction : exp_asleep

    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            conclude();
        end
    end

    task axw(input logic [7:0] a, input logic [31:0] v);
        logic aw, w;
        @(posedge clk);
        {awvalid, wvalid, bready, awaddr, wdata, wstrb} <= {3'h7, a, v, 4'hF};
        aw = 1;
        w = 1;
        while (aw || w) begin
            @(posedge clk);
            if (aw && awready === 1'b1) begin aw = 0; awvalid <= 1'b0; end
            if (w && wready === 1'b1) begin w = 0; wvalid <= 1'b0; end
        end
        while (bvalid !== 1'b1) @(posedge clk);
        r = bresp;
        bready <= 1'b0;
    endtask : axw

    task axr(input logic [7:0] a);
        @(posedge clk);
        {arvalid, rready, araddr} <= {2'h3, a};
        @(posedge clk);
        while (arready !== 1'b1) @(posedge clk);
        arvalid <= 1'b0;
        @(posedge clk);
        while (rvalid !== 1'b1) @(posedge clk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axr

    task pulse(input int k);
        @(posedge clk) ins <= 4'h1 << k;
        @(posedge clk) ins <= 4'h0;
    endtask : pulse

    task nic(input logic rs, input logic dr, input logic e, input logic [2:0] pr, input logic [2:0] cu);
        @(posedge clk) {raise, drop, en, prio, cur} <= {rs, dr, e, pr, cu};
        @(posedge clk) {raise, drop} <= 2'h0;
    endtask : nic

    task settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        axr(`SWC_OFF_CTRL); `CHK({r, d}, 34'h0)
        axr(`SWC_OFF_STAT); `CHK({r, d}, 34'h0)
        axr(8'h08); `CHK({r, d}, {`SWC_RESP_SLVERR, 32'h0})
        axw(8'h08, 32'hFFFFFFFF); `CHK(r, `SWC_RESP_SLVERR)
        for (int i = 0; i < 10; i++) begin
            {p, c} = 6'($random(seed));
            if (i == 0) {p, c} = 6'h1B;
            pulse(0); settle(0); `CHK(halt, 1'b1)
            nic(1, 0, i != 1, p, c); settle(2); `CHK(halt, exp_asleep(i != 1, p, c))
            nic(0, 1, 1, 0, 7);
            if (halt === 1'b1) begin nic(1, 0, 1, 0, 7); nic(0, 1, 1, 0, 7); end
        end
        nic(1, 0, 1, 0, 7); pulse(0); settle(1); `CHK({halt, eok}, 2'h1)
        nic(0, 1, 1, 0, 7);
        axw(`SWC_OFF_CTRL, 32'hC); `CHK(r, `SWC_RESP_OKAY)
        axr(`SWC_OFF_CTRL); `CHK({r, d}, 34'hC)
        pulse(0); nic(1, 0, 1, 1, 6);
        settle(2); `CHK(halt, 1'b1)
        axw(`SWC_OFF_CTRL, 32'h4); settle(1); `CHK({halt, eok}, 2'h0)
        axr(`SWC_OFF_STAT); `CHK(d, 32'h18)
        axw(`SWC_OFF_CTRL, 32'h0); settle(1); `CHK(eok, 1'b1)
        nic(0, 1, 1, 0, 7);
        pulse(2); settle(0); `CHK(ev, 1'b1)
        pulse(1); settle(0); `CHK({skip, halt, ev}, 3'h4)
        pulse(1); settle(0); `CHK(halt, 1'b1)
        axr(`SWC_OFF_STAT); `CHK(d[1:0], 2'h3)
        pulse(2); settle(1); `CHK({halt, ev}, 2'h0)
        pulse(1); nic(1, 0, 1, 2, 5); settle(1); `CHK({halt, wake}, 2'h1)
        nic(0, 1, 1, 0, 7);
        pulse(1); nic(1, 0, 0, 7, 0); settle(2); `CHK(halt, 1'b1)
        nic(0, 1, 0, 7, 0); pulse(2); settle(1); `CHK(halt, 1'b0)
        axw(`SWC_OFF_CTRL, 32'h2); pulse(1); nic(1, 0, 0, 7, 0);
        settle(2); `CHK(halt, 1'b0)
        nic(0, 1, 0, 7, 0);
        axw(`SWC_OFF_CTRL, 32'h1); pulse(3); settle(0); `CHK(halt, 1'b1)
        nic(1, 0, 1, 0, 7); nic(0, 1, 1, 0, 7);
        axw(`SWC_OFF_CTRL, 32'h0); pulse(3); settle(0); `CHK(halt, 1'b0)
        conclude();
    end
endmodule : swc_sleep_ctrl_tb_top
